// ---- verilog/macsec_event_params.svh ----
`ifndef MACSEC_EVENT_PARAMS_SVH
`define MACSEC_EVENT_PARAMS_SVH

// Register byte offsets on the register port.
`define OFF_IG_CRYPTO_STATUS 8'h00
`define OFF_EG_CRYPTO_STATUS 8'h04
`define OFF_IG_CRYPTO_EN     8'h08
`define OFF_EG_CRYPTO_EN     8'h0C
`define OFF_DROP_STATUS      8'h10
`define OFF_DROP_EN          8'h14
`define OFF_PN_THR_LOW       8'h18
`define OFF_PN_THR_HIGH      8'h1C
`define OFF_PN_UPD_LOW       8'h20
`define OFF_PN_UPD_HIGH      8'h24
`define OFF_PN_UPD_FLOW      8'h28
`define OFF_PN_UPD_CTRL      8'h2C
`define OFF_OVERRUN_COUNT    8'h30

// Crypto-core status bit positions.
`define CC_INPUT_ERR   0
`define CC_OUTPUT_ERR  1
`define CC_PROC_ERR    2
`define CC_CTX_ERR     3
`define CC_PN_THR      4
`define CC_PN_ROLL     5
`define CC_FATAL_ERR   14
`define CC_WIDTH       15
`define CC_IMPL_MASK   15'h403F

// Drop status bit positions.
`define DR_IG_CLASS    0
`define DR_IG_CONSIST  1
`define DR_IG_POST     2
`define DR_IG_MTU      3
`define DR_EG_CLASS    4
`define DR_EG_POST     5
`define DR_EG_MTU      6
`define DR_WIDTH       7

// Update control bit positions.
`define UPD_REQ_BIT    0
`define UPD_XPN_BIT    1
`define UPD_DONE_BIT   2
`define UPD_APPLY_BIT  3

// Reset values, all-ones constants and widths.
`define RST_THR        32'h0000_0000
`define FLOW_W         8
`define PN_ONES32      32'hFFFF_FFFF
`define PN_ONES64      64'hFFFF_FFFF_FFFF_FFFF
`define IG_IRQ_N       5
`define EG_IRQ_N       4

`endif

// ---- verilog/macsec_event_pkg.sv ----
`default_nettype none
package macsec_event_pkg;

  // States of the ingress packet-number update sequencer.
  typedef enum logic [2:0]
  {
    UPD_IDLE,
    UPD_READ,
    UPD_WAIT,
    UPD_CMP,
    UPD_DONE
  } upd_state_t;

endpackage : macsec_event_pkg
`default_nettype wire

// ---- verilog/w1c_event_reg.sv ----
`timescale 1ns/1ps
`default_nettype none
module w1c_event_reg #(
  parameter int W = 8
) (
  input  wire logic         i_core_clk,
  input  wire logic         i_reset,
  input  wire logic [W-1:0] i_set,
  input  wire logic         i_clr_wr,
  input  wire logic [W-1:0] i_clr_data,
  output logic      [W-1:0] o_pending
);

  logic [W-1:0] pending_q;

  // A set in the clear cycle wins so that no event is lost.
  always_ff @(posedge i_core_clk or posedge i_reset)
  begin
    if (i_reset)
    begin
      pending_q <= '0;
    end
    else
    begin
      pending_q <= (pending_q & ~(i_clr_wr ? i_clr_data : '0)) | i_set;
    end
  end

  assign o_pending = pending_q;

  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (i_reset);

  a_set_sticks: assert property (
    (|i_set) |=> ((pending_q & $past(i_set)) == $past(i_set)))
    else $error("Event did not set its pending bit.");

  a_clear_works: assert property (
    (i_clr_wr && !(|i_set)) |=> ((pending_q & $past(i_clr_data)) == '0))
    else $error("Write of ones did not clear pending bits.");

endmodule : w1c_event_reg
`default_nettype wire

// ---- verilog/pn_warning_monitor.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "macsec_event_params.svh"
module pn_warning_monitor (
  input  wire logic        i_core_clk,
  input  wire logic        i_reset,
  input  wire logic        i_pn_valid,
  input  wire logic [63:0] i_pn,
  input  wire logic        i_pn_xpn,
  input  wire logic [63:0] i_threshold,
  output logic             o_thr_evt,
  output logic             o_roll_evt
);

  logic thr_q;
  logic roll_q;
  logic all_ones;

  // A short number only looks at its low word; an extended one at all 64 bits.
  assign all_ones = i_pn_xpn ? (i_pn == `PN_ONES64) : (i_pn[31:0] == `PN_ONES32);

  // Warnings only; the frame path never sees these, so processing carries on.
  always_ff @(posedge i_core_clk or posedge i_reset)
  begin
    if (i_reset)
    begin
      thr_q  <= 1'b0;
      roll_q <= 1'b0;
    end
    else
    begin
      thr_q  <= i_pn_valid && (i_pn > i_threshold);
      roll_q <= i_pn_valid && all_ones;
    end
  end

  assign o_thr_evt  = thr_q;
  assign o_roll_evt = roll_q;

  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (i_reset);

  a_thr_detect: assert property (
    (i_pn_valid && (i_pn > i_threshold)) |=> o_thr_evt)
    else $error("Threshold crossing not flagged.");

  a_roll_detect: assert property (
    (i_pn_valid && !i_pn_xpn && (i_pn[31:0] == `PN_ONES32)) |=> o_roll_evt)
    else $error("32-bit rollover not flagged.");

endmodule : pn_warning_monitor
`default_nettype wire

// ---- verilog/macsec_event_and_pn_update.sv ----
// The placing of the registers and the plain strobed port were decided locally.
`timescale 1ns/1ps
`default_nettype none
`include "macsec_event_params.svh"
module macsec_event_and_pn_update
  import macsec_event_pkg::*;
(
  input  wire logic                      i_core_clk,
  input  wire logic                      i_reset,
  input  wire logic [7:0]                i_reg_addr,
  input  wire logic [31:0]               i_reg_wdata,
  input  wire logic                      i_reg_wr,
  input  wire logic                      i_reg_rd,
  output logic      [31:0]               o_reg_rdata,
  input  wire logic [3:0]                i_ig_core_err,
  input  wire logic                      i_ig_core_fatal,
  input  wire logic [3:0]                i_eg_core_err,
  input  wire logic                      i_eg_core_fatal,
  input  wire logic                      i_eg_pn_valid,
  input  wire logic [63:0]               i_eg_pn,
  input  wire logic                      i_eg_pn_xpn,
  input  wire logic                      i_ig_drop_class,
  input  wire logic                      i_ig_drop_consist,
  input  wire logic                      i_ig_drop_post,
  input  wire logic                      i_ig_drop_mtu,
  input  wire logic                      i_eg_drop_class,
  input  wire logic                      i_eg_drop_post,
  input  wire logic                      i_eg_drop_mtu,
  output logic                           o_ctx_rd,
  output logic                           o_ctx_wr,
  output logic      [`FLOW_W-1:0]        o_ctx_flow,
  input  wire logic                      i_ctx_rd_valid,
  input  wire logic [63:0]               i_ctx_next_pn,
  input  wire logic [31:0]               i_ctx_window,
  output logic      [63:0]               o_ctx_next_pn,
  output logic      [63:0]               o_ctx_lowest_pn,
  output logic      [`IG_IRQ_N-1:0]      o_ig_irq,
  output logic      [`EG_IRQ_N-1:0]      o_eg_irq
);

  logic [`CC_WIDTH-1:0] ig_cc_set;
  logic [`CC_WIDTH-1:0] eg_cc_set;
  logic [`CC_WIDTH-1:0] ig_cc_pend;
  logic [`CC_WIDTH-1:0] eg_cc_pend;
  logic [`CC_WIDTH-1:0] ig_cc_en_q;
  logic [`CC_WIDTH-1:0] eg_cc_en_q;
  logic [`DR_WIDTH-1:0] drop_set;
  logic [`DR_WIDTH-1:0] drop_pend;
  logic [`DR_WIDTH-1:0] drop_en_q;
  logic [63:0]          thr_q;
  logic [31:0]          upd_low_q;
  logic [31:0]          upd_high_q;
  logic [`FLOW_W-1:0]   upd_flow_q;
  logic                 upd_xpn_q;
  logic                 upd_req_q;
  logic                 upd_done_q;
  logic                 upd_apply_q;
  logic [63:0]          upd_target;
  logic [63:0]          ctx_pn_q;
  logic [31:0]          ctx_win_q;
  logic                 pn_thr_evt;
  logic                 pn_roll_evt;
  logic                 wr_ig_cc;
  logic                 wr_eg_cc;
  logic                 wr_drop;
  logic                 wr_ctrl;
  logic [31:0]          rdata_d;
  logic [31:0]          rdata_q;
  upd_state_t           state_q;

  // Write decodes for the clearing and control registers.
  assign wr_ig_cc = i_reg_wr && (i_reg_addr == `OFF_IG_CRYPTO_STATUS);
  assign wr_eg_cc = i_reg_wr && (i_reg_addr == `OFF_EG_CRYPTO_STATUS);
  assign wr_drop  = i_reg_wr && (i_reg_addr == `OFF_DROP_STATUS);
  assign wr_ctrl  = i_reg_wr && (i_reg_addr == `OFF_PN_UPD_CTRL);

  // Crypto-core causes mapped onto their status positions.
  always_comb
  begin
    ig_cc_set                 = '0;
    ig_cc_set[`CC_INPUT_ERR]  = i_ig_core_err[0];
    ig_cc_set[`CC_OUTPUT_ERR] = i_ig_core_err[1];
    ig_cc_set[`CC_PROC_ERR]   = i_ig_core_err[2];
    ig_cc_set[`CC_CTX_ERR]    = i_ig_core_err[3];
    ig_cc_set[`CC_FATAL_ERR]  = i_ig_core_fatal;
    eg_cc_set                 = '0;
    eg_cc_set[`CC_INPUT_ERR]  = i_eg_core_err[0];
    eg_cc_set[`CC_OUTPUT_ERR] = i_eg_core_err[1];
    eg_cc_set[`CC_PROC_ERR]   = i_eg_core_err[2];
    eg_cc_set[`CC_CTX_ERR]    = i_eg_core_err[3];
    eg_cc_set[`CC_PN_THR]     = pn_thr_evt;
    eg_cc_set[`CC_PN_ROLL]    = pn_roll_evt;
    eg_cc_set[`CC_FATAL_ERR]  = i_eg_core_fatal;
  end

  // Drop events, each kept on its own bit.
  always_comb
  begin
    drop_set                 = '0;
    drop_set[`DR_IG_CLASS]   = i_ig_drop_class;
    drop_set[`DR_IG_CONSIST] = i_ig_drop_consist;
    drop_set[`DR_IG_POST]    = i_ig_drop_post;
    drop_set[`DR_IG_MTU]     = i_ig_drop_mtu;
    drop_set[`DR_EG_CLASS]   = i_eg_drop_class;
    drop_set[`DR_EG_POST]    = i_eg_drop_post;
    drop_set[`DR_EG_MTU]     = i_eg_drop_mtu;
  end

  w1c_event_reg #(.W(`CC_WIDTH)) u_ig_cc (
    .i_core_clk (i_core_clk),
    .i_reset    (i_reset),
    .i_set      (ig_cc_set),
    .i_clr_wr   (wr_ig_cc),
    .i_clr_data (i_reg_wdata[`CC_WIDTH-1:0]),
    .o_pending  (ig_cc_pend)
  );

  w1c_event_reg #(.W(`CC_WIDTH)) u_eg_cc (
    .i_core_clk (i_core_clk),
    .i_reset    (i_reset),
    .i_set      (eg_cc_set),
    .i_clr_wr   (wr_eg_cc),
    .i_clr_data (i_reg_wdata[`CC_WIDTH-1:0]),
    .o_pending  (eg_cc_pend)
  );

  w1c_event_reg #(.W(`DR_WIDTH)) u_drop (
    .i_core_clk (i_core_clk),
    .i_reset    (i_reset),
    .i_set      (drop_set),
    .i_clr_wr   (wr_drop),
    .i_clr_data (i_reg_wdata[`DR_WIDTH-1:0]),
    .o_pending  (drop_pend)
  );

  pn_warning_monitor u_pn_mon (
    .i_core_clk  (i_core_clk),
    .i_reset     (i_reset),
    .i_pn_valid  (i_eg_pn_valid),
    .i_pn        (i_eg_pn),
    .i_pn_xpn    (i_eg_pn_xpn),
    .i_threshold (thr_q),
    .o_thr_evt   (pn_thr_evt),
    .o_roll_evt  (pn_roll_evt)
  );

  // Enable masks and threshold; masking lets software hold off a warning while it rekeys.
  always_ff @(posedge i_core_clk or posedge i_reset)
  begin
    if (i_reset)
    begin
      ig_cc_en_q <= '0;
      eg_cc_en_q <= '0;
      drop_en_q  <= '0;
      thr_q      <= {`RST_THR, `RST_THR};
    end
    else if (i_reg_wr)
    begin
      if (i_reg_addr == `OFF_IG_CRYPTO_EN)
        ig_cc_en_q <= i_reg_wdata[`CC_WIDTH-1:0] & `CC_IMPL_MASK;
      else if (i_reg_addr == `OFF_EG_CRYPTO_EN)
        eg_cc_en_q <= i_reg_wdata[`CC_WIDTH-1:0] & `CC_IMPL_MASK;
      else if (i_reg_addr == `OFF_DROP_EN)
        drop_en_q <= i_reg_wdata[`DR_WIDTH-1:0];
      else if (i_reg_addr == `OFF_PN_THR_LOW)
        thr_q[31:0] <= i_reg_wdata;
      else if (i_reg_addr == `OFF_PN_THR_HIGH)
        thr_q[63:32] <= i_reg_wdata;
    end
  end

  // Interrupt levels: pending and enabled, held until software clears the cause or masks it.
  always_comb
  begin
    o_ig_irq    = '0;
    o_eg_irq    = '0;
    o_ig_irq[0] = |(ig_cc_pend & ig_cc_en_q);
    o_ig_irq[1] = drop_pend[`DR_IG_CLASS] & drop_en_q[`DR_IG_CLASS];
    o_ig_irq[2] = drop_pend[`DR_IG_CONSIST] & drop_en_q[`DR_IG_CONSIST];
    o_ig_irq[3] = drop_pend[`DR_IG_POST] & drop_en_q[`DR_IG_POST];
    o_ig_irq[4] = drop_pend[`DR_IG_MTU] & drop_en_q[`DR_IG_MTU];
    o_eg_irq[0] = |(eg_cc_pend & eg_cc_en_q);
    o_eg_irq[1] = drop_pend[`DR_EG_CLASS] & drop_en_q[`DR_EG_CLASS];
    o_eg_irq[2] = drop_pend[`DR_EG_POST] & drop_en_q[`DR_EG_POST];
    o_eg_irq[3] = drop_pend[`DR_EG_MTU] & drop_en_q[`DR_EG_MTU];
  end

  // Update target and flow; software must load these before setting the request.
  always_ff @(posedge i_core_clk or posedge i_reset)
  begin
    if (i_reset)
    begin
      upd_low_q  <= '0;
      upd_high_q <= '0;
      upd_flow_q <= '0;
      upd_xpn_q  <= 1'b0;
    end
    else if (i_reg_wr)
    begin
      if (i_reg_addr == `OFF_PN_UPD_LOW)
        upd_low_q <= i_reg_wdata;
      else if (i_reg_addr == `OFF_PN_UPD_HIGH)
        upd_high_q <= i_reg_wdata;
      else if (i_reg_addr == `OFF_PN_UPD_FLOW)
        upd_flow_q <= i_reg_wdata[`FLOW_W-1:0];
      else if ((i_reg_addr == `OFF_PN_UPD_CTRL) && (state_q == UPD_IDLE))
        upd_xpn_q <= i_reg_wdata[`UPD_XPN_BIT];
    end
  end

  // A short-numbered flow ignores the upper word.
  assign upd_target = upd_xpn_q ? {upd_high_q, upd_low_q} : {32'h0000_0000, upd_low_q};

  // Request bit: set by software, cleared by the sequencer on completion.
  always_ff @(posedge i_core_clk or posedge i_reset)
  begin
    if (i_reset)
    begin
      upd_req_q <= 1'b0;
    end
    else if (state_q == UPD_DONE)
    begin
      upd_req_q <= 1'b0;
    end
    else if (wr_ctrl && i_reg_wdata[`UPD_REQ_BIT])
    begin
      upd_req_q <= 1'b1;
    end
  end

  // Sequencer: read the record, compare, write only when the stored value is lower.
  always_ff @(posedge i_core_clk or posedge i_reset)
  begin
    if (i_reset)
    begin
      state_q     <= UPD_IDLE;
      ctx_pn_q    <= '0;
      ctx_win_q   <= '0;
      upd_done_q  <= 1'b0;
      upd_apply_q <= 1'b0;
    end
    else
    begin
      case (state_q)
        UPD_IDLE:
        begin
          if (upd_req_q)
          begin
            state_q    <= UPD_READ;
            upd_done_q <= 1'b0;
          end
        end
        UPD_READ:
        begin
          state_q <= UPD_WAIT;
        end
        UPD_WAIT:
        begin
          if (i_ctx_rd_valid)
          begin
            ctx_pn_q  <= i_ctx_next_pn;
            ctx_win_q <= i_ctx_window;
            state_q   <= UPD_CMP;
          end
        end
        UPD_CMP:
        begin
          upd_apply_q <= (ctx_pn_q < upd_target);
          state_q     <= UPD_DONE;
        end
        default:
        begin
          upd_done_q <= 1'b1;
          state_q    <= UPD_IDLE;
        end
      endcase
    end
  end

  // Record port; the write strobe comes in the cycle before the request bit drops.
  assign o_ctx_rd   = (state_q == UPD_READ);
  assign o_ctx_wr   = (state_q == UPD_DONE) && upd_apply_q;
  assign o_ctx_flow = upd_flow_q;

  // Lowest acceptable number trails the new next number by the unchanged window, or is zero when the window is not below it.
  always_ff @(posedge i_core_clk or posedge i_reset)
  begin
    if (i_reset)
    begin
      o_ctx_next_pn   <= '0;
      o_ctx_lowest_pn <= '0;
    end
    else if (state_q == UPD_CMP)
    begin
      o_ctx_next_pn <= upd_target;
      if (upd_target > {32'h0000_0000, ctx_win_q})
        o_ctx_lowest_pn <= upd_target - {32'h0000_0000, ctx_win_q};
      else
        o_ctx_lowest_pn <= '0;
    end
  end

  // Read mux; unmapped addresses and the overrun count read as zero.
  always_comb
  begin
    rdata_d = '0;
    if (i_reg_addr == `OFF_IG_CRYPTO_STATUS)
      rdata_d[`CC_WIDTH-1:0] = ig_cc_pend;
    else if (i_reg_addr == `OFF_EG_CRYPTO_STATUS)
      rdata_d[`CC_WIDTH-1:0] = eg_cc_pend;
    else if (i_reg_addr == `OFF_IG_CRYPTO_EN)
      rdata_d[`CC_WIDTH-1:0] = ig_cc_en_q;
    else if (i_reg_addr == `OFF_EG_CRYPTO_EN)
      rdata_d[`CC_WIDTH-1:0] = eg_cc_en_q;
    else if (i_reg_addr == `OFF_DROP_STATUS)
      rdata_d[`DR_WIDTH-1:0] = drop_pend;
    else if (i_reg_addr == `OFF_DROP_EN)
      rdata_d[`DR_WIDTH-1:0] = drop_en_q;
    else if (i_reg_addr == `OFF_PN_THR_LOW)
      rdata_d = thr_q[31:0];
    else if (i_reg_addr == `OFF_PN_THR_HIGH)
      rdata_d = thr_q[63:32];
    else if (i_reg_addr == `OFF_PN_UPD_LOW)
      rdata_d = upd_low_q;
    else if (i_reg_addr == `OFF_PN_UPD_HIGH)
      rdata_d = upd_high_q;
    else if (i_reg_addr == `OFF_PN_UPD_FLOW)
      rdata_d[`FLOW_W-1:0] = upd_flow_q;
    else if (i_reg_addr == `OFF_PN_UPD_CTRL)
    begin
      rdata_d[`UPD_REQ_BIT]   = upd_req_q;
      rdata_d[`UPD_XPN_BIT]   = upd_xpn_q;
      rdata_d[`UPD_DONE_BIT]  = upd_done_q;
      rdata_d[`UPD_APPLY_BIT] = upd_apply_q;
    end
    else if (i_reg_addr == `OFF_OVERRUN_COUNT)
      rdata_d = '0;
  end

  // Read data stand only in the cycle after the strobe.
  always_ff @(posedge i_core_clk or posedge i_reset)
  begin
    if (i_reset)
      rdata_q <= '0;
    else if (i_reg_rd)
      rdata_q <= rdata_d;
    else
      rdata_q <= '0;
  end

  assign o_reg_rdata = rdata_q;

  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (i_reset);

  // A mask write in the event cycle may lower the level legally, so it is left out.
  a_fatal_irq: assert property (
    (i_eg_core_fatal && eg_cc_en_q[`CC_FATAL_ERR]
      && !(i_reg_wr && (i_reg_addr == `OFF_EG_CRYPTO_EN))) |=> o_eg_irq[0])
    else $error("Fatal error did not raise egress crypto interrupt.");

  a_consist_irq: assert property (
    (i_ig_drop_consist && drop_en_q[`DR_IG_CONSIST]
      && !(i_reg_wr && (i_reg_addr == `OFF_DROP_EN))) |=> o_ig_irq[2])
    else $error("Consistency drop did not raise its interrupt.");

  a_mtu_hold: assert property (
    (o_eg_irq[3] && !wr_drop && !(i_reg_wr && (i_reg_addr == `OFF_DROP_EN)))
      |=> o_eg_irq[3])
    else $error("Length-limit interrupt dropped without a clear.");

  a_req_done: assert property (
    (state_q == UPD_DONE) |=> !upd_req_q)
    else $error("Request bit not cleared on completion.");

  a_no_lower_write: assert property (
    o_ctx_wr |-> (ctx_pn_q < o_ctx_next_pn))
    else $error("Record written with a target not above stored value.");

  a_window_kept: assert property (
    (o_ctx_wr && (o_ctx_next_pn > {32'h0000_0000, ctx_win_q}))
      |-> (o_ctx_next_pn - o_ctx_lowest_pn == {32'h0000_0000, ctx_win_q}))
    else $error("Lowest acceptable number does not keep the window.");

  a_overrun_zero: assert property (
    (i_reg_rd && (i_reg_addr == `OFF_OVERRUN_COUNT)) |=> (o_reg_rdata == '0))
    else $error("Overrun count read nonzero.");

  a_thr_irq: assert property (
    (pn_thr_evt && eg_cc_en_q[`CC_PN_THR]
      && !(i_reg_wr && (i_reg_addr == `OFF_EG_CRYPTO_EN))) |=> o_eg_irq[0])
    else $error("Threshold event did not raise egress crypto interrupt.");

endmodule : macsec_event_and_pn_update
`default_nettype wire

// ---- bench/macsec_event_and_pn_update_tb.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "macsec_event_params.svh"
module macsec_event_and_pn_update_tb;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic [7:0]  addr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic        wr = 1'b0;
  logic        rd = 1'b0;
  logic [31:0] rdata;
  logic [3:0]  ig_err = 4'h0;
  logic [3:0]  eg_err = 4'h0;
  logic        ig_fat = 1'b0;
  logic        eg_fat = 1'b0;
  logic        pn_vld = 1'b0;
  logic [63:0] pn = 64'h0;
  logic        pn_xpn = 1'b0;
  logic [6:0]  drop = 7'h0;
  logic        ctx_rd;
  logic        ctx_wr;
  logic [`FLOW_W-1:0] ctx_flow;
  logic        ctx_vld = 1'b0;
  logic [63:0] ctx_pn = 64'h0;
  logic [31:0] ctx_win = 32'h0;
  logic [63:0] ctx_npn;
  logic [63:0] ctx_low;
  logic [4:0]  ig_irq;
  logic [3:0]  eg_irq;
  int          num_errors = 0;
  int          total_checks = 0;
  logic [31:0] d;
  logic [31:0] en;
  logic [31:0] b;

  // Half period of 10 ns gives the 50 MHz core clock.
  always #10 clk = ~clk;

  macsec_event_and_pn_update dut (
    .i_core_clk(clk), .i_reset(rst), .i_reg_addr(addr), .i_reg_wdata(wdata),
    .i_reg_wr(wr), .i_reg_rd(rd), .o_reg_rdata(rdata), .i_ig_core_err(ig_err),
    .i_ig_core_fatal(ig_fat), .i_eg_core_err(eg_err), .i_eg_core_fatal(eg_fat),
    .i_eg_pn_valid(pn_vld), .i_eg_pn(pn), .i_eg_pn_xpn(pn_xpn),
    .i_ig_drop_class(drop[0]), .i_ig_drop_consist(drop[1]), .i_ig_drop_post(drop[2]),
    .i_ig_drop_mtu(drop[3]), .i_eg_drop_class(drop[4]), .i_eg_drop_post(drop[5]),
    .i_eg_drop_mtu(drop[6]), .o_ctx_rd(ctx_rd), .o_ctx_wr(ctx_wr), .o_ctx_flow(ctx_flow),
    .i_ctx_rd_valid(ctx_vld), .i_ctx_next_pn(ctx_pn), .i_ctx_window(ctx_win),
    .o_ctx_next_pn(ctx_npn), .o_ctx_lowest_pn(ctx_low), .o_ig_irq(ig_irq), .o_eg_irq(eg_irq)
  );

  task automatic check(input string name, input logic [63:0] seen, input logic [63:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("ERROR %s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  task automatic stop_test;
    $display("checks %0d errors %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : stop_test

  // A write and a read each hold their strobe for exactly one cycle.
  task automatic wr_reg(input logic [7:0] a, input logic [31:0] v);
    @(posedge clk);
    addr <= a;
    wdata <= v;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask : wr_reg

  task automatic rd_reg(input logic [7:0] a, output logic [31:0] v);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 v = rdata;
  endtask : rd_reg

  // Drop irq bits follow the status bits gated by their enables.
  function automatic logic [8:0] drop_irq(input logic [6:0] s, input logic [6:0] m);
    logic [6:0] x;
    x = s & m;
    return {x[6:4], 1'b0, x[3:0], 1'b0};
  endfunction : drop_irq

  // One update request; expectations come from the stored value and window.
  task automatic pn_upd(input logic [63:0] t, input logic x, input logic [63:0] st,
                        input logic [31:0] w);
    logic [63:0] tgt;
    logic        ap;
    logic        seen;
    logic [7:0]  f;
    tgt = x ? t : {32'h0, t[31:0]};
    ap = st < tgt;
    seen = 1'b0;
    f = 8'($urandom);
    wr_reg(`OFF_PN_UPD_LOW, t[31:0]);
    wr_reg(`OFF_PN_UPD_HIGH, t[63:32]);
    wr_reg(`OFF_PN_UPD_FLOW, {24'h0, f});
    wr_reg(`OFF_PN_UPD_CTRL, {30'h0, x, 1'b1});
    for (int i = 0; i < 10 && !ctx_rd; i++)
      @(posedge clk) #1;
    check("ctx_rd", ctx_rd, 1'b1);
    if (!ctx_rd)
      stop_test();
    check("ctx_flow", ctx_flow, f);
    @(posedge clk);
    ctx_vld <= 1'b1;
    ctx_pn <= st;
    ctx_win <= w;
    @(posedge clk);
    ctx_vld <= 1'b0;
    ctx_pn <= ~st;
    ctx_win <= ~w;
    for (int i = 0; i < 8; i++)
      @(posedge clk) #1 if (ctx_wr) seen = 1'b1;
    check("ctx_wr", seen, ap);
    if (ap)
    begin
      check("next_pn", ctx_npn, tgt);
      check("lowest_pn", ctx_low, (tgt > w) ? tgt - w : 64'h0);
    end
    rd_reg(`OFF_PN_UPD_CTRL, d);
    check("upd_ctrl", d & 32'hD, {28'h0, ap, 3'b100});
  endtask : pn_upd

  initial
  begin
    void'($urandom(32'h142cbad1));
    repeat (6) @(posedge clk);
    check("irq_in_reset", {ig_irq, eg_irq}, 9'h0);
    rst <= 1'b0;
    // Every core error bit and the fatal bit, ingress and egress at once, random enables.
    for (int k = 0; k < 5; k++)
    begin
      b = (k < 4) ? (32'h1 << k) : 32'h4000;
      en = $urandom & 32'h403F;
      wr_reg(`OFF_IG_CRYPTO_EN, en);
      wr_reg(`OFF_EG_CRYPTO_EN, ~en);
      rd_reg(`OFF_EG_CRYPTO_EN, d);
      check("eg_en_rd", d, ~en & 32'h403F);
      @(posedge clk);
      ig_err <= b[3:0];
      eg_err <= b[3:0];
      ig_fat <= b[14];
      eg_fat <= b[14];
      @(posedge clk);
      {ig_err, eg_err, ig_fat, eg_fat} <= 10'h0;
      repeat (3) @(posedge clk) #1;
      check("ig_crypto_irq", ig_irq[0], |(b & en));
      check("eg_crypto_irq", eg_irq[0], |(b & ~en));
      rd_reg(`OFF_IG_CRYPTO_STATUS, d);
      check("ig_crypto_st", d, b);
      rd_reg(`OFF_EG_CRYPTO_STATUS, d);
      check("eg_crypto_st", d, b);
      wr_reg(`OFF_IG_CRYPTO_STATUS, b);
      wr_reg(`OFF_EG_CRYPTO_STATUS, b);
      rd_reg(`OFF_IG_CRYPTO_STATUS, d);
      check("ig_crypto_clr", {d, ig_irq[0], eg_irq[0]}, 34'h0);
    end
    // Each drop class alone; a clear of the wrong bit must not remove it.
    for (int j = 0; j < 7; j++)
    begin
      en = $urandom & 32'h7F;
      wr_reg(`OFF_DROP_EN, en);
      @(posedge clk);
      drop <= 7'(1 << j);
      @(posedge clk);
      drop <= 7'h0;
      wr_reg(`OFF_DROP_STATUS, ~(32'h1 << j));
      #1;
      check("drop_irq", {eg_irq, ig_irq}, drop_irq(7'(1 << j), en[6:0]));
      rd_reg(`OFF_DROP_STATUS, d);
      check("drop_st", d, 32'h1 << j);
      wr_reg(`OFF_DROP_STATUS, 32'h1 << j);
      #1;
      check("drop_clr", {eg_irq, ig_irq}, 9'h0);
    end
    // Threshold boundary, just above it, and both roll-over formats; each event is cleared afterwards.
    en = $urandom & 32'h7FFF_FFFF;
    wr_reg(`OFF_PN_THR_LOW, en);
    wr_reg(`OFF_PN_THR_HIGH, 32'h0);
    wr_reg(`OFF_EG_CRYPTO_EN, 32'h30);
    rd_reg(`OFF_PN_THR_LOW, d);
    check("thr_rd", d, en);
    for (int c = 0; c < 4; c++)
    begin
      @(posedge clk);
      pn_vld <= 1'b1;
      pn_xpn <= c != 2;
      pn <= (c == 0) ? {32'h0, en} : (c == 1) ? {32'h0, en} + 64'h1 :
            (c == 2) ? 64'h0000_0000_FFFF_FFFF : 64'hFFFF_FFFF_FFFF_FFFF;
      b = (c == 0) ? 32'h0 : (c == 1) ? 32'h10 : 32'h30;
      @(posedge clk);
      pn_vld <= 1'b0;
      repeat (2) @(posedge clk) #1;
      check("pn_irq", eg_irq[0], |b);
      rd_reg(`OFF_EG_CRYPTO_STATUS, d);
      check("pn_st", d, b);
      wr_reg(`OFF_EG_CRYPTO_EN, 32'h20);
      #1;
      check("pn_mask", eg_irq[0], b[5]);
      wr_reg(`OFF_EG_CRYPTO_STATUS, 32'h30);
      wr_reg(`OFF_EG_CRYPTO_EN, 32'h30);
    end
    // Forward update, equal value, larger stored value, saturating window.
    pn_upd({$urandom, $urandom}, 1'b1, 64'h0, $urandom & 32'hFF);
    d = $urandom;
    pn_upd({32'h1, d}, 1'b0, {32'h0, d}, 32'h40);
    pn_upd({32'h0, d}, 1'b0, {32'h1, 32'h0}, 32'h0);
    pn_upd(64'h0000_0000_0000_0010, 1'b1, 64'h8, 32'hFFFF_FFFF);
    // Overrun counts are summed by software; the block keeps no counter for them.
    rd_reg(`OFF_OVERRUN_COUNT, d);
    check("overrun", d, 32'h0);
    rd_reg(8'hFC, d);
    check("unmapped", d, 32'h0);
    stop_test();
  end

  // A hang ends the run with a counted mismatch.
  initial
  begin
    #1ms;
    num_errors++;
    stop_test();
  end
endmodule : macsec_event_and_pn_update_tb
`default_nettype wire
